// ---- hdl/irxcs_pkg.sv ----
package irxcs_pkg;
   // context register window
   localparam logic [11:0] IRXCS_SET_OFS = 12'h400;
   localparam logic [11:0] IRXCS_CLR_OFS = 12'h404;
   localparam logic [11:0] IRXCS_CTX_STRIDE = 12'h020;
   // field positions in the lower half of the control word
   localparam int IRXCS_RUN_BIT = 15;
   localparam int IRXCS_WAKE_BIT = 12;
   localparam int IRXCS_DEAD_BIT = 11;
   localparam int IRXCS_ACTIVE_BIT = 10;
   localparam int IRXCS_SPD_LSB = 5;
   localparam int IRXCS_EVT_LSB = 0;
   // received-speed encodings
   localparam logic [2:0] IRXCS_SPD_S100 = 3'h0;
   localparam logic [2:0] IRXCS_SPD_S200 = 3'h1;
   localparam logic [2:0] IRXCS_SPD_S400 = 3'h2;
   // acknowledge and event codes
   localparam logic [4:0] IRXCS_EVT_NONE = 5'h00;
   localparam logic [4:0] IRXCS_EVT_LONG_PACKET = 5'h02;
   localparam logic [4:0] IRXCS_EVT_OVERRUN = 5'h05;
   localparam logic [4:0] IRXCS_EVT_DESCRIPTOR_READ = 5'h06;
   localparam logic [4:0] IRXCS_EVT_DATA_WRITE = 5'h08;
   localparam logic [4:0] IRXCS_EVT_UNKNOWN = 5'h0E;
   localparam logic [4:0] IRXCS_ACK_COMPLETE = 5'h11;
   localparam logic [4:0] IRXCS_ACK_DATA_ERROR = 5'h1D;
   // reset values
   localparam logic [2:0] IRXCS_SPD_RESET = 3'h0;
   localparam logic [31:0] IRXCS_ZERO_WORD = 32'h0000_0000;
   typedef enum logic [2:0] {
      CTX_IDLE,
      CTX_FETCH,
      CTX_RECV,
      CTX_STALL,
      CTX_DEAD
   } irxcs_state_t;
endpackage : irxcs_pkg

// ---- hdl/irxcs_evt_classify.sv ----
`timescale 1ns/1ps
module irxcs_evt_classify
   import irxcs_pkg::*;
(
   // mode and packet status
   input wire logic fill_mode_in,
   input wire logic [2:0] speed_in,
   input wire logic len_err_in,
   input wire logic crc_err_in,
   input wire logic overrun_in,
   input wire logic long_pkt_in,
   // verdict
   output logic [4:0] code_out,
   output logic backout_out,
   output logic update_out
);
   logic spd_ok;
   always_comb begin
      spd_ok = (speed_in == IRXCS_SPD_S100) || (speed_in == IRXCS_SPD_S200)
         || (speed_in == IRXCS_SPD_S400);
      code_out = IRXCS_ACK_COMPLETE;
      backout_out = 1'b0;
      update_out = 1'b1;
      if (fill_mode_in) begin
         // bad packets vanish: status keeps the previous good packet
         if (len_err_in || crc_err_in || overrun_in) begin
            backout_out = 1'b1;
            update_out = 1'b0;
         end else if (!spd_ok) begin
            code_out = IRXCS_EVT_UNKNOWN;
         end
      end else begin
         if (overrun_in) begin
            code_out = IRXCS_EVT_OVERRUN;
         end else if (long_pkt_in) begin
            code_out = IRXCS_EVT_LONG_PACKET;
         end else if (len_err_in || crc_err_in) begin
            code_out = IRXCS_ACK_DATA_ERROR;
         end else if (!spd_ok) begin
            code_out = IRXCS_EVT_UNKNOWN;
         end
      end
   end
endmodule : irxcs_evt_classify

// ---- hdl/irxcs_ctx_status.sv ----
`timescale 1ns/1ps
// What this block does
// - software sets run to start descriptor processing, clears it to halt
// - hardware changes run only on system or software reset
// - reserved bits 14-13 and 9-8 always read as zero
// - software sets wake to resume; a descriptor fetch clears it unless a wake set lands in the same cycle
// - dead sets on fatal error, clears when software clears run
// - active is one whenever the context processes descriptors
// - speed field reports the receive speed code as received: 000, 001, 010 or any other code
// - fill mode reports ack_complete or descriptor/data/unknown events
// - fill mode backs out length mismatch, crc error and overrun packets
// - packet-per-buffer mode adds data error, long and overrun codes
// - fill mode packs packets back to back; else one buffer each
module irxcs_ctx_status
   import irxcs_pkg::*;
#(
   parameter logic [11:0] CTX_INDEX = 12'h000
)
(
   // clock and reset
   input wire logic CLOCK_IN,
   input wire logic RST_N_IN,
   input wire logic SOFT_RESET_IN,
   // register access
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   input wire logic [11:0] REG_ADDR_IN,
   input wire logic [31:0] REG_WDATA_IN,
   output logic [31:0] REG_RDATA_OUT,
   // mode from the upper control half
   input wire logic FILL_BUFFER_MODE_IN,
   // descriptor fetch
   output logic DESC_FETCH_REQ_OUT,
   input wire logic DESC_FETCH_DONE_IN,
   input wire logic DESC_EMPTY_IN,
   input wire logic DESC_READ_ERR_IN,
   // packet completion
   input wire logic PKT_DONE_IN,
   input wire logic [2:0] PKT_SPEED_IN,
   input wire logic PKT_LEN_ERR_IN,
   input wire logic PKT_CRC_ERR_IN,
   input wire logic PKT_OVERRUN_IN,
   input wire logic PKT_LONG_IN,
   input wire logic DATA_WRITE_ERR_IN,
   input wire logic BUFFER_FULL_IN,
   // status
   output logic BACKOUT_OUT,
   output logic RUN_OUT,
   output logic ACTIVE_OUT,
   output logic DEAD_OUT
);
   irxcs_state_t state_q, state_d;
   logic run_q, run_d;
   logic wake_q, wake_d;
   logic dead_q, dead_d;
   logic [2:0] spd_q, spd_d;
   logic [4:0] evt_q, evt_d;
   logic [31:0] rdata_q, rdata_d;
   logic req_q, req_d;
   logic backout_q, backout_d;
   logic [11:0] set_addr;
   logic [11:0] clr_addr;
   logic wr_set;
   logic wr_clr;
   logic [31:0] status_word;
   logic [4:0] cls_code;
   logic cls_backout;
   logic cls_update;

   irxcs_evt_classify u_classify (
      .fill_mode_in(FILL_BUFFER_MODE_IN),
      .speed_in(PKT_SPEED_IN),
      .len_err_in(PKT_LEN_ERR_IN),
      .crc_err_in(PKT_CRC_ERR_IN),
      .overrun_in(PKT_OVERRUN_IN),
      .long_pkt_in(PKT_LONG_IN),
      .code_out(cls_code),
      .backout_out(cls_backout),
      .update_out(cls_update)
   );

   // register decode and control bits
   always_comb begin
      set_addr = IRXCS_SET_OFS + 12'(CTX_INDEX * IRXCS_CTX_STRIDE);
      clr_addr = IRXCS_CLR_OFS + 12'(CTX_INDEX * IRXCS_CTX_STRIDE);
      wr_set = REG_WR_IN && (REG_ADDR_IN == set_addr);
      wr_clr = REG_WR_IN && (REG_ADDR_IN == clr_addr);
      run_d = run_q;
      if (SOFT_RESET_IN) begin
         run_d = 1'b0;
      end else if (wr_set && REG_WDATA_IN[IRXCS_RUN_BIT]) begin
         run_d = 1'b1;
      end else if (wr_clr && REG_WDATA_IN[IRXCS_RUN_BIT]) begin
         run_d = 1'b0;
      end
      wake_d = wake_q;
      if (SOFT_RESET_IN) begin
         wake_d = 1'b0;
      end else if (wr_set && REG_WDATA_IN[IRXCS_WAKE_BIT]) begin
         // a wake landing on a fetch survives it
         wake_d = 1'b1;
      end else if (DESC_FETCH_DONE_IN && state_q == CTX_FETCH) begin
         wake_d = 1'b0;
      end
   end

   // context sequencer
   always_comb begin
      state_d = state_q;
      dead_d = dead_q;
      spd_d = spd_q;
      evt_d = evt_q;
      backout_d = 1'b0;
      case (state_q)
         CTX_IDLE: begin
            if (run_q) begin
               state_d = CTX_FETCH;
            end
         end
         CTX_FETCH: begin
            if (DESC_FETCH_DONE_IN) begin
               if (DESC_READ_ERR_IN) begin
                  state_d = CTX_DEAD;
                  evt_d = IRXCS_EVT_DESCRIPTOR_READ;
               end else if (DESC_EMPTY_IN) begin
                  state_d = CTX_STALL;
               end else begin
                  state_d = CTX_RECV;
               end
            end
         end
         CTX_RECV: begin
            if (PKT_DONE_IN && DATA_WRITE_ERR_IN) begin
               state_d = CTX_DEAD;
               evt_d = IRXCS_EVT_DATA_WRITE;
            end else if (PKT_DONE_IN) begin
               backout_d = cls_backout;
               if (cls_update) begin
                  spd_d = PKT_SPEED_IN;
                  evt_d = cls_code;
               end
               // own buffer per packet unless packing is on
               if (!FILL_BUFFER_MODE_IN || BUFFER_FULL_IN) begin
                  state_d = CTX_FETCH;
               end
            end else if (FILL_BUFFER_MODE_IN && BUFFER_FULL_IN) begin
               state_d = CTX_FETCH;
            end
         end
         CTX_STALL: begin
            if (wake_q) begin
               state_d = CTX_FETCH;
            end
         end
         CTX_DEAD: begin
            state_d = CTX_DEAD;
         end
         default: begin
            state_d = CTX_IDLE;
         end
      endcase
      // halt last, so a cleared run drops dead in the very next cycle
      if (!run_q || SOFT_RESET_IN) begin
         state_d = CTX_IDLE;
         backout_d = 1'b0;
      end
      if (state_d == CTX_DEAD) begin
         dead_d = 1'b1;
      end else if (!run_q) begin
         dead_d = 1'b0;
      end
      req_d = (state_d == CTX_FETCH);
   end

   // readback; upper half belongs to other logic and reads zero here
   always_comb begin
      status_word = IRXCS_ZERO_WORD;
      status_word[IRXCS_RUN_BIT] = run_q;
      status_word[IRXCS_WAKE_BIT] = wake_q;
      status_word[IRXCS_DEAD_BIT] = dead_q;
      // active from state, so it lags a cleared run bit by one cycle
      status_word[IRXCS_ACTIVE_BIT] = (state_q == CTX_FETCH)
         || (state_q == CTX_RECV);
      status_word[IRXCS_SPD_LSB +: 3] = spd_q;
      status_word[IRXCS_EVT_LSB +: 5] = evt_q;
      rdata_d = rdata_q;
      if (REG_RD_IN) begin
         if (REG_ADDR_IN == set_addr || REG_ADDR_IN == clr_addr) begin
            rdata_d = status_word;
         end else begin
            rdata_d = IRXCS_ZERO_WORD;
         end
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (!RST_N_IN) begin
         state_q <= CTX_IDLE;
         run_q <= 1'b0;
         wake_q <= 1'b0;
         dead_q <= 1'b0;
         spd_q <= IRXCS_SPD_RESET;
         evt_q <= IRXCS_EVT_NONE;
         rdata_q <= IRXCS_ZERO_WORD;
         req_q <= 1'b0;
         backout_q <= 1'b0;
      end else begin
         state_q <= state_d;
         run_q <= run_d;
         wake_q <= wake_d;
         dead_q <= dead_d;
         spd_q <= spd_d;
         evt_q <= evt_d;
         rdata_q <= rdata_d;
         req_q <= req_d;
         backout_q <= backout_d;
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (!RST_N_IN) begin
         RUN_OUT <= 1'b0;
         ACTIVE_OUT <= 1'b0;
         DEAD_OUT <= 1'b0;
      end else begin
         RUN_OUT <= run_d;
         ACTIVE_OUT <= (state_d == CTX_FETCH) || (state_d == CTX_RECV);
         DEAD_OUT <= dead_d;
      end
   end

   assign REG_RDATA_OUT = rdata_q;
   assign DESC_FETCH_REQ_OUT = req_q;
   assign BACKOUT_OUT = backout_q;
endmodule : irxcs_ctx_status

// ---- testbench/irxcs_host_model.sv ----
`timescale 1ns/1ps
module irxcs_host_model (
   // descriptor link
   input wire logic clk_in,
   input wire logic req_in,
   input wire logic [1:0] lag_in,
   input wire logic empty_in,
   input wire logic err_in,
   output logic done_out,
   output logic empty_out,
   output logic err_out
);
   logic [1:0] cnt_q = 2'h0;
   logic tog_q = 1'b0;
   // qualifiers toggle outside the pulse so stale values never match
   assign empty_out = done_out ? empty_in : tog_q;
   assign err_out = done_out ? err_in : ~tog_q;
   // one done per request, lag_in + 1 cycles after it rises
   always @(posedge clk_in) begin
      tog_q <= ~tog_q;
      done_out <= req_in && !done_out && cnt_q == lag_in;
      cnt_q <= (req_in && !done_out) ? cnt_q + 2'h1 : 2'h0;
   end
endmodule : irxcs_host_model

// ---- testbench/irxcs_ctx_status_assertions.sv ----
`timescale 1ns/1ps
module irxcs_ctx_status_assertions
   import irxcs_pkg::*;
#(
   parameter logic [11:0] CTX_INDEX = 12'h000
)
(
   // clock, reset, registers
   input wire logic CLOCK_IN,
   input wire logic RST_N_IN,
   input wire logic SOFT_RESET_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   input wire logic [11:0] REG_ADDR_IN,
   input wire logic [31:0] REG_RDATA_OUT,
   // context
   input wire logic FILL_BUFFER_MODE_IN,
   input wire logic PKT_DONE_IN,
   input wire logic DESC_FETCH_REQ_OUT,
   input wire logic BACKOUT_OUT,
   input wire logic RUN_OUT,
   input wire logic ACTIVE_OUT,
   input wire logic DEAD_OUT
);
   localparam logic [11:0] SA = IRXCS_SET_OFS + IRXCS_CTX_STRIDE * CTX_INDEX;
   default clocking @(posedge CLOCK_IN);
   endclocking
   default disable iff (!RST_N_IN);
   a_run_only: assert property ($changed(RUN_OUT) |->
      $past(REG_WR_IN) || $past(SOFT_RESET_IN)) else $error("run moved");
   a_run_start: assert property ($rose(RUN_OUT) |=>
      ACTIVE_OUT && DESC_FETCH_REQ_OUT) else $error("no start");
   a_run_stop: assert property ($fell(RUN_OUT) |-> ##[0:1]
      !ACTIVE_OUT) else $error("no stop");
   a_dead_clear: assert property (!RUN_OUT |=> !DEAD_OUT)
      else $error("dead kept");
   a_dead_halt: assert property (DEAD_OUT |-> !ACTIVE_OUT)
      else $error("dead active");
   a_fetch_busy: assert property (DESC_FETCH_REQ_OUT |-> ACTIVE_OUT)
      else $error("fetch idle");
   a_reserved_bits_zero: assert property (REG_RD_IN |=>
      (REG_RDATA_OUT & 32'hFFFF_6300) == 32'h0) else $error("reserved_bits set");
   a_unmapped_zero: assert property (REG_RD_IN && REG_ADDR_IN != SA &&
      REG_ADDR_IN != SA + 12'h004 |=> REG_RDATA_OUT == 32'h0)
      else $error("unmapped data");
   a_ppb_keep: assert property (PKT_DONE_IN && !FILL_BUFFER_MODE_IN
      |=> !BACKOUT_OUT) else $error("ppb backout");
   c_start: cover property ($rose(RUN_OUT));
   c_backout: cover property (BACKOUT_OUT);
   c_dead: cover property ($rose(DEAD_OUT));
endmodule : irxcs_ctx_status_assertions
bind irxcs_ctx_status irxcs_ctx_status_assertions #(.CTX_INDEX(CTX_INDEX))
   u_chk (.CLOCK_IN, .RST_N_IN, .SOFT_RESET_IN, .REG_WR_IN, .REG_RD_IN,
   .REG_ADDR_IN, .REG_RDATA_OUT, .FILL_BUFFER_MODE_IN, .PKT_DONE_IN,
   .DESC_FETCH_REQ_OUT, .BACKOUT_OUT, .RUN_OUT, .ACTIVE_OUT, .DEAD_OUT);

// ---- testbench/tb_irxcs_ctx_status.sv ----
`timescale 1ns/1ps
module tb_irxcs_ctx_status
   import irxcs_pkg::*;
;
   localparam logic [11:0] SA = IRXCS_SET_OFS + IRXCS_CTX_STRIDE;
   localparam logic [11:0] CA = IRXCS_CLR_OFS + IRXCS_CTX_STRIDE;
   logic clk = 0, rst_n = 0, srst = 0, wr = 0, rd = 0, fill = 0, full = 0;
   logic pkt = 0, len = 0, crc = 0, ovr = 0, lng = 0, m_e = 0, m_x = 0;
   logic done, emp, err, req, bo, run, act, dead, rd_q = 0, pk_q = 0;
   logic dwe = 0;
   logic [31:0] ex, fx;
   logic [1:0] lag = '0;
   logic [2:0] spd = '0, sp = '0, s;
   logic [3:0] e;
   logic [4:0] ev = '0;
   logic [11:0] addr = '0;
   logic [31:0] wd = '0, rdat, exp_q[$];
   logic bo_q[$];
   int mismatches = 0, compares = 0;
   logic [3:0] pe [9] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3};
   logic [4:0] pv [9] = '{5'h11, 5'h11, 5'h11, 5'h0E, 5'h02, 5'h05, 5'h1D,
      5'h1D, 5'h05};
   irxcs_ctx_status #(.CTX_INDEX(12'h001)) DUT (
      .CLOCK_IN(clk), .RST_N_IN(rst_n), .SOFT_RESET_IN(srst),
      .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_ADDR_IN(addr),
      .REG_WDATA_IN(wd), .REG_RDATA_OUT(rdat), .FILL_BUFFER_MODE_IN(fill),
      .DESC_FETCH_REQ_OUT(req), .DESC_FETCH_DONE_IN(done),
      .DESC_EMPTY_IN(emp), .DESC_READ_ERR_IN(err), .PKT_DONE_IN(pkt),
      .PKT_SPEED_IN(spd), .PKT_LEN_ERR_IN(len), .PKT_CRC_ERR_IN(crc),
      .PKT_OVERRUN_IN(ovr), .PKT_LONG_IN(lng), .DATA_WRITE_ERR_IN(dwe),
      .BUFFER_FULL_IN(full), .BACKOUT_OUT(bo), .RUN_OUT(run),
      .ACTIVE_OUT(act), .DEAD_OUT(dead));
   irxcs_host_model HOST (.clk_in(clk), .req_in(req), .lag_in(lag),
      .empty_in(m_e), .err_in(m_x), .done_out(done), .empty_out(emp),
      .err_out(err));
   function automatic logic [31:0] w(input logic [3:0] f);
      return {16'h0000, f[3], 2'b00, f[2:0], 2'b00, sp, ev};
   endfunction : w
   task automatic check(input string n, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s exp %h seen %h", n, exp, seen);
      end
   endtask : check
   task automatic op(input logic we, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= we;
      rd <= !we;
      addr <= a;
      wd <= we ? d : $urandom;
      if (!we) exp_q.push_back(d);
      @(posedge clk);
      wr <= 0;
      rd <= 0;
   endtask : op
   // fixed floor, then bounded wait for any fetch to finish
   task automatic settle();
      repeat (3) @(posedge clk);
      // request is looked at where it has settled, off the edge
      @(negedge clk);
      for (int i = 0; i < 9 && req; i++) @(negedge clk);
      @(posedge clk);
   endtask : settle
   task automatic packet(input logic [2:0] sv, input logic [3:0] ef,
      input logic [4:0] v, input logic b);
      @(posedge clk);
      pkt <= 1;
      spd <= sv;
      {len, crc, ovr, lng} <= ef;
      lag <= 2'($urandom_range(3));
      bo_q.push_back(b);
      if (!b) {sp, ev} = {sv, v};
      @(posedge clk);
      pkt <= 0;
      {len, crc, ovr, lng} <= 4'($urandom);
      settle();
      op(0, SA, w(4'h9));
   endtask : packet
   task automatic kick();
      full <= 1;
      @(posedge clk);
      full <= 0;
      settle();
   endtask : kick
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : stop_test
   always @(posedge clk) begin
      rd_q <= rd;
      pk_q <= pkt;
   end
   always @(negedge clk) begin
      if (rd_q) begin
         ex = exp_q.pop_front();
         fx = {28'h0, ex[15], ex[11], ex[10], 1'b0};
         check("rdata", rdat, ex);
         check("flags", {28'h0, run, dead, act, req}, fx);
      end
      if (pk_q) check("backout", {31'h0, bo}, {31'h0, bo_q.pop_front()});
   end
   initial forever #10 clk = ~clk;
   initial begin
      #300us;
      mismatches++;
      stop_test();
   end
   initial begin
      void'($urandom(21));
      repeat (12) @(posedge clk);
      rst_n <= 1;
      op(0, SA, '0);
      op(0, CA, '0);
      op(0, 12'h400, '0);
      op(1, SA, 32'hFFFF_AFFF);
      settle();
      op(0, SA, w(4'h9));
      for (int i = 0; i < 9; i++) begin
         s = i < 4 ? 3'(i) : 3'($urandom_range(2));
         packet(s, pe[i], pv[i], 1'b0);
      end
      op(1, CA, 32'h0000_8000);
      repeat (3) @(posedge clk);
      op(0, CA, w(4'h0));
      $display("test ppb done");
      fill <= 1;
      op(1, SA, 32'h0000_8000);
      settle();
      for (int i = 0; i < 8; i++) begin
         e = i == 0 ? 4'h1 : 4'($urandom);
         s = i == 0 ? 3'h3 : 3'($urandom_range(3));
         packet(s, e, s == 3'h3 ? 5'h0E : 5'h11,
            |e[3:1]);
      end
      $display("test fill done");
      m_e <= 1;
      kick();
      m_e <= 0;
      op(1, SA, 32'h0000_1000);
      settle();
      op(0, SA, w(4'h9));
      m_x <= 1;
      kick();
      m_x <= 0;
      ev = 5'h06;
      op(0, SA, w(4'hA));
      op(1, CA, 32'h0000_8000);
      repeat (3) @(posedge clk);
      op(0, SA, w(4'h0));
      $display("test wake dead done");
      op(1, SA, 32'h0000_8000);
      settle();
      srst <= 1;
      @(posedge clk);
      srst <= 0;
      repeat (2) @(posedge clk);
      op(0, SA, w(4'h0));
      $display("test soft reset done");
      op(1, SA, 32'h0000_8000);
      settle();
      dwe <= 1;
      pkt <= 1;
      bo_q.push_back(1'b0);
      @(posedge clk);
      dwe <= 0;
      pkt <= 0;
      ev = 5'h08;
      op(0, SA, w(4'hA));
      $display("test write error done");
      stop_test();
   end
endmodule : tb_irxcs_ctx_status
